/* File: rjc_defs.svh */
// Register offsets, codes and scale constants for the judgment and conversion block
`ifndef RJC_DEFS_SVH
`define RJC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RJC_OFS_CTRL    8'h00
`define RJC_OFS_CONFIRM 8'h04
`define RJC_OFS_UPPER   8'h08
`define RJC_OFS_LOWER   8'h0C
`define RJC_OFS_REF     8'h10
`define RJC_OFS_PCT     8'h14
`define RJC_OFS_PERM    8'h18
`define RJC_OFS_RANGE   8'h1C
`define RJC_OFS_ZERO    8'h20
`define RJC_OFS_STATUS  8'h24
`define RJC_OFS_DEV     8'h28
`define RJC_OFS_LEN     8'h2C
`define RJC_OFS_MEAS    8'h30

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RJC_CONF_APPLY   0
`define RJC_CONF_DISCARD 1
`define RJC_RANGE_AUTO   4
`define RJC_ST_LIM_REJ   4
`define RJC_ST_REF_REJ   5
`define RJC_ST_RNG_REJ   6
`define RJC_ST_ZERO_CLR  7

// ----------------------------------------------------------------
// Grade codes, scales and reset values
// ----------------------------------------------------------------
`define RJC_GRADE_NONE 2'h0
`define RJC_GRADE_HIGH 2'h1
`define RJC_GRADE_IN   2'h2
`define RJC_GRADE_LOW  2'h3
`define RJC_PCT_SCALE  64'sh2710
`define RJC_LEN_SCALE  64'sh3E8
`define RJC_RANGE_300M 4'h2
`define RJC_RANGE_RST  4'h0
`define RJC_NUM_RANGES 10

`endif

/* File: rjc_fe_model.sv */
// Behavioural model of the measurement front end
`timescale 1ns/1ps
`default_nettype none

module rjc_fe_model (
   input wire logic core_clk,
   output rjc_pkg::rjc_meas_t meas_out
);
   import rjc_pkg::*;

   // Quiet pins at time zero
   initial meas_out = '0;

   // Value and flags settle 4 edges before the toggle and hold 5 after
   task automatic send(input logic [31:0] v, input logic p, input logic n, input logic e);
      meas_out.value <= v;
      meas_out.pos_ovf <= p;
      meas_out.neg_ovf <= n;
      meas_out.err <= e;
      repeat (4) @(posedge core_clk);
      meas_out.toggle <= ~meas_out.toggle;
      repeat (5) @(posedge core_clk);
      // Released lines no longer carry the old word
      meas_out <= {meas_out.toggle, ~v, ~p, ~n, ~e};
   endtask
endmodule

`default_nettype wire

/* File: rjc_judge.sv */
// Judgment and conversion control with Avalon-MM register access
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
`include "rjc_defs.svh"
`default_nettype none

module rjc_judge #(
   parameter int NUM_RANGES = `RJC_NUM_RANGES // Selectable ranges
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire rjc_pkg::rjc_meas_t meas_in,
   output rjc_pkg::rjc_panel_t panel
);
   import rjc_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   generate
      if (NUM_RANGES < 3 || NUM_RANGES > 16) begin : g_bad
         $error("NUM_RANGES must lie in 3 to 16");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Mode exclusions applied to a staged mode
   function automatic rjc_mode_t resolve(input rjc_mode_t s, input rjc_mode_t l);
      rjc_mode_t m;
      m = s;
      if (m.trise_en && m.len_en) begin
         // Newly enabled one wins; both new, length wins
         if (!l.len_en) begin
            m.trise_en = 1'b0;
         end else begin
            m.len_en = 1'b0;
         end
      end
      if (m.trise_en) begin
         m.comp_en = 1'b0;
         m.temperature_correction = 1'b0;
      end
      if (m.len_en) begin
         m.comp_en = 1'b0;
      end
      if (m.comp_en) begin
         m.ilog_en = 1'b0;
      end
      return m;
   endfunction

   // Three-way grade against limits
   function automatic logic [1:0] grade_of(input logic signed [31:0] v, input logic signed [31:0] up,
                                           input logic signed [31:0] lo);
      logic [1:0] g;
      g = `RJC_GRADE_IN;
      if (v > up) begin
         g = `RJC_GRADE_HIGH;
      end else if (v < lo) begin
         g = `RJC_GRADE_LOW;
      end
      return g;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   rjc_state_t s; // Registered state
   rjc_state_t next_s; // Next state

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Single process: bus slave, confirm, measurement path
   always_comb begin
      logic [5:0] widx;
      logic [31:0] rd;
      logic signed [31:0] v;
      logic signed [63:0] delta;
      logic signed [63:0] q;
      logic signed [31:0] up;
      logic signed [31:0] lo;
      logic [1:0] g;
      rjc_mode_t m;
      logic limits_ok;
      widx = '0;
      rd = '0;
      v = '0;
      delta = '0;
      q = '0;
      up = '0;
      lo = '0;
      g = `RJC_GRADE_NONE;
      m = '0;
      limits_ok = 1'b0;
      next_s = s;

      // Pin synchroniser, second stage reads first only
      next_s.sync1 = meas_in;
      next_s.sync2 = s.sync1;
      next_s.tog3 = s.sync2.toggle;

      // Read mux
      widx = s.bus == RJC_BUS_IDLE ? avs_address[7:2] : avs_address[7:2];
      case ({avs_address[7:2], 2'b00})
         `RJC_OFS_CTRL: begin
            rd = 32'(s.stage.mode);
         end
         `RJC_OFS_CONFIRM: begin
            rd = 32'(s.live.mode);
         end
         `RJC_OFS_UPPER: begin
            rd = s.stage.upper;
         end
         `RJC_OFS_LOWER: begin
            rd = s.stage.lower;
         end
         `RJC_OFS_REF: begin
            rd = s.stage.refv;
         end
         `RJC_OFS_PCT: begin
            rd = s.stage.pct;
         end
         `RJC_OFS_PERM: begin
            rd = s.stage.per_m;
         end
         `RJC_OFS_RANGE: begin
            rd = {27'h0, s.auto_rng, s.range};
         end
         `RJC_OFS_ZERO: begin
            rd = s.zero;
         end
         `RJC_OFS_STATUS: begin
            rd = {24'h0, s.zero_clr, s.rng_rej, s.ref_rej, s.lim_rej, 2'h0, s.panel.grade};
         end
         `RJC_OFS_DEV: begin
            rd = s.dev;
         end
         `RJC_OFS_LEN: begin
            rd = s.len;
         end
         `RJC_OFS_MEAS: begin
            rd = s.meas;
         end
         default: begin
            rd = '0; // Unmapped reads zero
         end
      endcase

      // Bus handshake: one wait cycle, answer next
      case (s.bus)
         RJC_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               next_s.bus = RJC_BUS_DONE;
               next_s.waitrequest = 1'b0;
               next_s.readdata = avs_read ? rd : 32'h0;
            end
         end
         RJC_BUS_DONE: begin
            next_s.bus = RJC_BUS_IDLE;
            next_s.waitrequest = 1'b1;
            if (avs_write) begin
               case ({widx, 2'b00})
                  `RJC_OFS_CTRL: begin
                     // Edits go to the staged copy only
                     next_s.stage.mode = rjc_mode_t'(9'(merge(32'(s.stage.mode), avs_writedata,
                                                              avs_byteenable)));
                  end
                  `RJC_OFS_UPPER: begin
                     next_s.stage.upper = merge(s.stage.upper, avs_writedata, avs_byteenable);
                  end
                  `RJC_OFS_LOWER: begin
                     next_s.stage.lower = merge(s.stage.lower, avs_writedata, avs_byteenable);
                  end
                  `RJC_OFS_REF: begin
                     next_s.stage.refv = merge(s.stage.refv, avs_writedata, avs_byteenable);
                  end
                  `RJC_OFS_PCT: begin
                     next_s.stage.pct = merge(s.stage.pct, avs_writedata, avs_byteenable);
                  end
                  `RJC_OFS_PERM: begin
                     next_s.stage.per_m = merge(s.stage.per_m, avs_writedata, avs_byteenable);
                  end
                  `RJC_OFS_CONFIRM: begin
                     if (avs_byteenable[0] && avs_writedata[`RJC_CONF_APPLY]) begin
                        m = resolve(s.stage.mode, s.live.mode);
                        limits_ok = $signed(s.stage.upper) >= $signed(s.stage.lower);
                        if (s.stage.mode.rel_mode && s.stage.refv == 32'h0) begin
                           next_s.ref_rej = 1'b1; // Whole confirm refused
                        end else begin
                           next_s.live.mode = m;
                           next_s.live.refv = s.stage.refv;
                           next_s.live.pct = s.stage.pct;
                           next_s.live.per_m = s.stage.per_m;
                           if (s.stage.mode.rel_mode || limits_ok) begin
                              next_s.live.upper = s.stage.upper;
                              next_s.live.lower = s.stage.lower;
                           end else begin
                              next_s.lim_rej = 1'b1; // Old limits kept
                           end
                           if ((m.high_current != s.live.mode.high_current) ||
                               (m.offset_voltage_compensation !=
                                s.live.mode.offset_voltage_compensation)) begin
                              next_s.zero = '0;
                              next_s.zero_clr = 1'b1;
                           end
                        end
                        // Staged mode shows the resolved mode, also when the confirm is refused
                        next_s.stage.mode = m;
                     end else if (avs_byteenable[0] && avs_writedata[`RJC_CONF_DISCARD]) begin
                        next_s.stage = s.live; // Edits dropped
                     end
                  end
                  `RJC_OFS_RANGE: begin
                     if (avs_byteenable[0]) begin
                        if (s.live.mode.comp_en) begin
                           next_s.rng_rej = 1'b1; // Range and auto refused
                        end else if ({1'b0, avs_writedata[3:0]} < 5'(NUM_RANGES)) begin
                           next_s.range = avs_writedata[3:0];
                           next_s.auto_rng = avs_writedata[`RJC_RANGE_AUTO];
                        end
                     end
                  end
                  `RJC_OFS_ZERO: begin
                     next_s.zero = merge(s.zero, avs_writedata, avs_byteenable);
                  end
                  `RJC_OFS_STATUS: begin
                     // Write one to clear sticky flags
                     if (avs_byteenable[0]) begin
                        next_s.lim_rej = s.lim_rej & ~avs_writedata[`RJC_ST_LIM_REJ];
                        next_s.ref_rej = s.ref_rej & ~avs_writedata[`RJC_ST_REF_REJ];
                        next_s.rng_rej = s.rng_rej & ~avs_writedata[`RJC_ST_RNG_REJ];
                        next_s.zero_clr = s.zero_clr & ~avs_writedata[`RJC_ST_ZERO_CLR];
                     end
                  end
                  default: begin
                     next_s.zero = next_s.zero; // Unmapped writes ignored
                  end
               endcase
            end
         end
         default: begin
            next_s.bus = RJC_BUS_IDLE;
            next_s.waitrequest = 1'b1;
         end
      endcase

      // ----------------------------------------------------------------
      // Measurement path, once per new value
      // ----------------------------------------------------------------
      next_s.panel.buzzer = 1'b0;
      if (s.tog3 != s.sync2.toggle) begin
         v = $signed(s.sync2.value) - $signed(s.zero);
         next_s.meas = v;
         // Limits, relative ones from reference and percentage
         delta = $signed({32'h0, s.live.refv}) * $signed({32'h0, s.live.pct}) / `RJC_PCT_SCALE;
         if (s.live.mode.rel_mode) begin
            up = 32'(($signed({32'h0, s.live.refv}) + delta));
            lo = 32'(($signed({32'h0, s.live.refv}) - delta));
         end else begin
            up = s.live.upper;
            lo = s.live.lower;
         end
         // Deviation in hundredths of a percent
         if (s.live.refv != 32'h0) begin
            q = 64'(v) * `RJC_PCT_SCALE / $signed({32'h0, s.live.refv}) - `RJC_PCT_SCALE;
            next_s.dev = q[31:0];
         end
         // Length in millimetres; zero divisor gives zero
         if (s.live.per_m != 32'h0) begin
            q = 64'(v) * `RJC_LEN_SCALE / $signed({32'h0, s.live.per_m});
            next_s.len = q[31:0];
         end else begin
            next_s.len = '0;
         end
         // Error over overflow over comparison
         if (s.sync2.err) begin
            g = `RJC_GRADE_NONE;
         end else if (s.sync2.pos_ovf) begin
            g = `RJC_GRADE_HIGH;
         end else if (s.sync2.neg_ovf) begin
            g = `RJC_GRADE_LOW;
         end else begin
            g = grade_of(v, up, lo);
         end
         if (!s.live.mode.comp_en) begin
            g = `RJC_GRADE_NONE;
         end
         next_s.panel.grade = g;
         next_s.panel.buzzer = s.live.mode.buzz_en && (g != `RJC_GRADE_NONE);
      end

      // Grade cleared as soon as comparator is off
      if (!s.live.mode.comp_en) begin
         next_s.panel.grade = `RJC_GRADE_NONE;
      end

      // Panel lamp and status outputs
      next_s.panel.lamp_green = next_s.panel.grade == `RJC_GRADE_IN;
      next_s.panel.lamp_red = (next_s.panel.grade == `RJC_GRADE_HIGH) ||
                              (next_s.panel.grade == `RJC_GRADE_LOW);
      // Higher current only flows in the 300 milliohm range
      next_s.panel.test_current_high = s.live.mode.high_current && (s.range == `RJC_RANGE_300M);
      next_s.panel.high_current_ind = s.live.mode.high_current && (s.range == `RJC_RANGE_300M);
      next_s.panel.range = s.range;
      next_s.panel.auto_range = s.auto_rng;
      next_s.panel.ilog_avail = !s.live.mode.comp_en;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Synchronous reset; settings return to factory values
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s <= '0;
         // Synchroniser keeps running, so no false toggle follows reset
         s.sync1 <= next_s.sync1;
         s.sync2 <= next_s.sync2;
         s.tog3 <= next_s.tog3;
         s.bus <= RJC_BUS_IDLE;
         s.waitrequest <= 1'b1;
         s.range <= `RJC_RANGE_RST;
         s.panel.ilog_avail <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs straight from the state register
   // ----------------------------------------------------------------
   assign avs_readdata = s.readdata;
   assign avs_waitrequest = s.waitrequest;
   assign panel = s.panel;

endmodule

`default_nettype wire

/* File: rjc_judge_assertions.sv */
// Port-level checks bound onto the judgment block
`timescale 1ns/1ps
`include "rjc_defs.svh"
`default_nettype none

module rjc_judge_assertions (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire rjc_pkg::rjc_meas_t meas_in,
   input wire rjc_pkg::rjc_panel_t panel
);
   import rjc_pkg::*;

   // ------------------------------------------------
   // One clock domain, reset masks everything
   // ------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   // Bus answer comes one cycle after the request and stands one cycle
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest did not drop one cycle after request");
   wait_stand_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
      else $error("waitrequest dropped with no request");

   // Lamps follow the grade code
   lamp_map_a: assert property (panel.lamp_green == (panel.grade == `RJC_GRADE_IN) &&
      panel.lamp_red == (panel.grade inside {`RJC_GRADE_HIGH, `RJC_GRADE_LOW}))
      else $error("lamp colour does not match grade");
   // A grade only exists while interval logging is withheld
   ilog_block_a: assert property (panel.grade != `RJC_GRADE_NONE |-> !panel.ilog_avail)
      else $error("grade shown while interval logging available");
   // Range is frozen while the comparator runs
   range_lock_a: assert property ($changed({panel.range, panel.auto_range}) |-> $past(panel.ilog_avail))
      else $error("range changed with comparator on");
   cur_ind_a: assert property (panel.high_current_ind == panel.test_current_high &&
      (!panel.test_current_high || panel.range == `RJC_RANGE_300M))
      else $error("high current indicator wrong");
   // Buzzer is a single pulse that needs a grade
   buzz_pulse_a: assert property (panel.buzzer |-> panel.grade != `RJC_GRADE_NONE ##1 !panel.buzzer)
      else $error("buzzer pulse wrong");
   err_none_a: assert property ($changed(meas_in.toggle) && meas_in.err |-> ##4 panel.grade == `RJC_GRADE_NONE)
      else $error("error measurement graded");
   ovf_high_a: assert property ($changed(meas_in.toggle) && meas_in.pos_ovf && !meas_in.err &&
      !panel.ilog_avail |-> ##4 panel.grade == `RJC_GRADE_HIGH)
      else $error("overflow not graded high");
   // A fresh grade always traces back to a toggle four edges earlier
   grade_cause_a: assert property ($changed(panel.grade) && panel.grade != `RJC_GRADE_NONE |->
      $past(meas_in.toggle, 3) != $past(meas_in.toggle, 4))
      else $error("grade changed without a measurement");
endmodule

bind rjc_judge rjc_judge_assertions chk_i (.core_clk, .reset, .avs_address, .avs_read, .avs_write,
   .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .meas_in, .panel);

`default_nettype wire

/* File: rjc_judge_end.sv */
// Empty companion unit; all logic lives in the judgment module
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: rjc_pkg.sv */
// Types shared by the judgment and conversion block
`default_nettype none
package rjc_pkg;

   // ----------------------------------------------------------------
   // Bus handshake states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RJC_BUS_IDLE = 2'b01,
      RJC_BUS_DONE = 2'b10
   } rjc_bus_t;

   // Mode bits, msb first, equals the CTRL register layout
   typedef struct packed {
      logic ilog_en;                     // Bit 8 interval logging
      logic high_current;                // Bit 7 300 mA test current
      logic offset_voltage_compensation; // Bit 6
      logic temperature_correction;      // Bit 5
      logic len_en;                      // Bit 4 length conversion
      logic trise_en;                    // Bit 3 temperature rise
      logic buzz_en;                     // Bit 2 judgment sound
      logic rel_mode;                    // Bit 1 relative mode
      logic comp_en;                     // Bit 0 comparator
   } rjc_mode_t;

   // One full setting set, staged or live
   typedef struct packed {
      rjc_mode_t mode;
      logic [31:0] upper;
      logic [31:0] lower;
      logic [31:0] refv;
      logic [31:0] pct;
      logic [31:0] per_m;
   } rjc_set_t;

   // Measurement from the front end
   typedef struct packed {
      logic toggle;
      logic [31:0] value;
      logic pos_ovf;
      logic neg_ovf;
      logic err;
   } rjc_meas_t;

   // Panel outputs
   typedef struct packed {
      logic lamp_green;
      logic lamp_red;
      logic buzzer;
      logic high_current_ind;
      logic test_current_high;
      logic auto_range;
      logic ilog_avail;
      logic [3:0] range;
      logic [1:0] grade;
   } rjc_panel_t;

   // Whole module state
   typedef struct packed {
      rjc_bus_t bus;
      logic waitrequest;
      logic [31:0] readdata;
      rjc_set_t stage;
      rjc_set_t live;
      logic [3:0] range;
      logic auto_rng;
      logic [31:0] zero;
      logic lim_rej;
      logic ref_rej;
      logic rng_rej;
      logic zero_clr;
      logic [31:0] dev;
      logic [31:0] len;
      logic [31:0] meas;
      rjc_meas_t sync1;
      rjc_meas_t sync2;
      logic tog3;
      rjc_panel_t panel;
   } rjc_state_t;

endpackage

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the judgment and conversion block
`timescale 1ns/1ps
`include "rjc_defs.svh"
`default_nettype none

module tb_top;
   import rjc_pkg::*;

   // ------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------
   localparam logic [1:0] g_no = `RJC_GRADE_NONE;
   localparam logic [1:0] g_hi = `RJC_GRADE_HIGH;
   localparam logic [1:0] g_in = `RJC_GRADE_IN;
   localparam logic [1:0] g_lo = `RJC_GRADE_LOW;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] avs_byteenable = 4'hF; // Full words only
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   rjc_meas_t meas_in;
   rjc_panel_t panel;
   int fails = 0;
   int num_checks = 0;
   int buzzes = 0; // Judgment sound pulses seen

   always #5 core_clk = ~core_clk;

   // Count buzzer pulses, one per sounded judgment
   always @(posedge core_clk) begin
      if (panel.buzzer === 1'b1) begin
         buzzes++;
      end
   end

   rjc_judge uut (.core_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_byteenable,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .meas_in, .panel);
   rjc_fe_model fe (.core_clk, .meas_out(meas_in));

   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      num_checks++;
      if (got !== want) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask

   // Idle edge first, so a release and a new request never share a step
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) @(posedge core_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic [31:0] m = 32'hFFFFFFFF);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q & m, want);
   endtask

   task automatic conf();
      wr(`RJC_OFS_CONFIRM, 32'h1);
   endtask

   // One measurement, then grade and lamps
   task automatic meas(input logic [31:0] v, input logic p, input logic n, input logic e, input logic [1:0] g);
      fe.send(v, p, n, e);
      chk(32'(panel.grade), 32'(g));
      chk(32'({panel.lamp_green, panel.lamp_red}), 32'({g == g_in, g == g_hi || g == g_lo}));
   endtask

   task automatic end_sim();
      if (fails == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_reset();
      rd(`RJC_OFS_CTRL, 32'h0);
      rd(8'hFC, 32'h0);
      chk(32'(panel.ilog_avail), 32'h1);
      chk(32'(panel.test_current_high), 32'h0);
   endtask

   // Limits 80..100, boundaries, overflow, error, range lock, discard, bad limits
   task automatic t_abs();
      wr(`RJC_OFS_UPPER, 32'h64);
      wr(`RJC_OFS_LOWER, 32'h50);
      wr(`RJC_OFS_CTRL, 32'h105);
      conf();
      rd(`RJC_OFS_CONFIRM, 32'h5);
      meas(32'h65, 1'b0, 1'b0, 1'b0, g_hi);
      chk(32'(panel.ilog_avail), 32'h0);
      meas(32'h64, 1'b0, 1'b0, 1'b0, g_in);
      meas(32'h50, 1'b0, 1'b0, 1'b0, g_in);
      meas(32'h4F, 1'b0, 1'b0, 1'b0, g_lo);
      meas(32'h0, 1'b1, 1'b0, 1'b0, g_hi);
      meas(32'h0, 1'b0, 1'b1, 1'b0, g_lo);
      meas(32'h5A, 1'b0, 1'b0, 1'b1, g_no);
      wr(`RJC_OFS_RANGE, 32'h12);
      rd(`RJC_OFS_STATUS, 32'h40, 32'h40);
      chk(32'({panel.auto_range, panel.range}), 32'h0);
      wr(`RJC_OFS_UPPER, 32'h32);
      meas(32'h5A, 1'b0, 1'b0, 1'b0, g_in);
      wr(`RJC_OFS_CONFIRM, 32'h2);
      rd(`RJC_OFS_UPPER, 32'h64);
      wr(`RJC_OFS_UPPER, 32'hA);
      wr(`RJC_OFS_LOWER, 32'h14);
      conf();
      rd(`RJC_OFS_STATUS, 32'h10, 32'h10);
      meas(32'h5A, 1'b0, 1'b0, 1'b0, g_in);
      chk(32'(buzzes), 32'h8);
   endtask

   // Reference 1000 with 10 percent window
   task automatic t_rel();
      wr(`RJC_OFS_CTRL, 32'h3);
      conf();
      rd(`RJC_OFS_STATUS, 32'h20, 32'h20);
      rd(`RJC_OFS_CONFIRM, 32'h5);
      wr(`RJC_OFS_REF, 32'h3E8);
      wr(`RJC_OFS_PCT, 32'h3E8);
      conf();
      meas(32'h44D, 1'b0, 1'b0, 1'b0, g_hi);
      meas(32'h383, 1'b0, 1'b0, 1'b0, g_lo);
      meas(32'h44C, 1'b0, 1'b0, 1'b0, g_in);
      rd(`RJC_OFS_DEV, 32'h3E8);
      chk(32'(buzzes), 32'h8);
   endtask

   // Exclusions resolved at confirm, then length of 15000 over 200
   task automatic t_excl();
      wr(`RJC_OFS_CTRL, 32'h29);
      conf();
      rd(`RJC_OFS_CONFIRM, 32'h8);
      chk(32'(panel.grade), 32'(g_no));
      wr(`RJC_OFS_CTRL, 32'h19);
      conf();
      rd(`RJC_OFS_CONFIRM, 32'h10);
      wr(`RJC_OFS_PERM, 32'hC8);
      conf();
      meas(32'h3A98, 1'b0, 1'b0, 1'b0, g_no);
      rd(`RJC_OFS_LEN, 32'h124F8);
      wr(`RJC_OFS_CTRL, 32'h18);
      conf();
      rd(`RJC_OFS_CONFIRM, 32'h8);
   endtask

   // Test current and compensation changes wipe the zero offset
   task automatic t_current();
      wr(`RJC_OFS_RANGE, 32'h2);
      wr(`RJC_OFS_ZERO, 32'h5);
      wr(`RJC_OFS_CTRL, 32'h80);
      conf();
      rd(`RJC_OFS_ZERO, 32'h0);
      rd(`RJC_OFS_STATUS, 32'h80, 32'h80);
      chk(32'({panel.test_current_high, panel.high_current_ind, panel.range}), 32'h32);
      wr(`RJC_OFS_ZERO, 32'h5);
      wr(`RJC_OFS_CTRL, 32'hC0);
      conf();
      rd(`RJC_OFS_ZERO, 32'h0);
      wr(`RJC_OFS_CTRL, 32'h40);
      conf();
      rd(`RJC_OFS_CONFIRM, 32'h40);
      chk(32'(panel.test_current_high), 32'h0);
   endtask

   // Power loss before confirm drops edits; no false measurement follows
   task automatic t_power();
      wr(`RJC_OFS_CTRL, 32'h1);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rd(`RJC_OFS_CTRL, 32'h0);
      rd(`RJC_OFS_MEAS, 32'h0);
   endtask

   // ------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------
   initial begin
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_abs();
      t_rel();
      t_excl();
      t_current();
      t_power();
      end_sim();
   end

   // Whole run needs about three hundred cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      end_sim();
   end
endmodule

`default_nettype wire
